// >>> hdl/dr_consts.vh
// Constants of the disturbance recorder: sizes, register offsets, defaults
`ifndef DR_CONSTS_VH
`define DR_CONSTS_VH

`define DR_AW 17
`define DR_DEPTH 131072
`define DR_LEN_CAP 17'h1FFFF
`define DR_AN_W 16
`define DR_SMP_W 160
`define DR_DIR_N 32
`define DR_DIR_AW 5
`define DR_DCH_N 32
`define DR_DSRC_W 64

`define DR_SMP_PER_CYC 12
`define DR_MAINS_HZ 50
`define DR_SMP_PER_CS ((`DR_SMP_PER_CYC * `DR_MAINS_HZ) / 100)

`define DR_REG_CTRL 8'h00
`define DR_REG_DUR 8'h04
`define DR_REG_POS 8'h08
`define DR_REG_STAT 8'h0C
`define DR_REG_ACH 8'h10
`define DR_REG_CT 8'h14
`define DR_REG_VT 8'h18
`define DR_REG_DIDX 8'h20
`define DR_REG_DCFG 8'h24
`define DR_REG_RSEL 8'h28
`define DR_REG_RINFO 8'h2C
`define DR_REG_RPTR 8'h30
`define DR_REG_RWORD 8'h34
`define DR_REG_RDATA 8'h38
`define DR_REG_SCALE 8'h3C

`define DR_CTRL_EN 0
`define DR_CTRL_EXT 1
`define DR_CTRL_DEF 2'h1
`define DR_DUR_DEF 11'h096
`define DR_DUR_MIN 11'h00A
`define DR_DUR_MAX 11'h41A
`define DR_POS_DEF 10'h14D
`define DR_POS_MAX 10'h3E8
`define DR_POS_DIV 24'h0003E8
`define DR_ACH_DEF 32'h87654210
`define DR_RATIO_DEF 32'h00010000
`define DR_TRIG_NONE 2'h0
`define DR_TRIG_LH 2'h1
`define DR_TRIG_HL 2'h2
`define DR_TRIP_CH 2

`endif

// >>> hdl/dr_recorder.v
// Disturbance recorder: sample capture around a trigger, record store, Wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "dr_consts.vh"

module dr_recorder (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sample_valid,
  input wire [`DR_AN_W-1:0] phase_a_voltage,
  input wire [`DR_AN_W-1:0] phase_b_voltage,
  input wire [`DR_AN_W-1:0] phase_c_voltage,
  input wire [`DR_AN_W-1:0] sync_check_voltage,
  input wire [`DR_AN_W-1:0] phase_a_current,
  input wire [`DR_AN_W-1:0] phase_b_current,
  input wire [`DR_AN_W-1:0] phase_c_current,
  input wire [`DR_AN_W-1:0] neutral_current,
  input wire [`DR_AN_W-1:0] sensitive_earth_current,
  input wire [`DR_DSRC_W-1:0] dig_src,
  output reg capture_active
);

  localparam ST_IDLE = 2'b01;
  localparam ST_POST = 2'b10;

  function [`DR_AN_W-1:0] an_pick;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: an_pick = phase_a_voltage;
        4'h1: an_pick = phase_b_voltage;
        4'h2: an_pick = phase_c_voltage;
        4'h3: an_pick = sync_check_voltage;
        4'h4: an_pick = phase_a_current;
        4'h5: an_pick = phase_b_current;
        4'h6: an_pick = phase_c_current;
        4'h7: an_pick = neutral_current;
        4'h8: an_pick = sensitive_earth_current;
        default: an_pick = {`DR_AN_W{1'b0}};
      endcase
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b])
          wmerge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Current sources use the CT ratio, voltages the VT ratio
  function is_current;
    input [3:0] sel;
    begin
      is_current = (sel >= 4'h4);
    end
  endfunction

  reg [1:0] ctrl_r;
  reg [10:0] dur_r;
  reg [9:0] pos_r;
  reg [31:0] ach_r;
  reg [31:0] ct_r;
  reg [31:0] vt_r;
  reg [7:0] dcfg_r [0:`DR_DCH_N-1];
  reg [4:0] didx_r;
  reg [4:0] rsel_r;
  reg [16:0] rptr_r;
  reg [2:0] rword_r;
  reg [`DR_SMP_W-1:0] mem [0:`DR_DEPTH-1];
  reg [`DR_SMP_W-1:0] mem_q_r;
  reg [1:0] st_r;
  reg [`DR_AW-1:0] base_r;
  reg [12:0] hist_r;
  reg [12:0] pre_cnt_r;
  reg [12:0] post_r;
  reg [16:0] len_r;
  reg [12:0] rec_pre_r;
  reg [12:0] rec_rot_r;
  reg [31:0] dig_prev_r;
  reg [`DR_AW-1:0] dir_start [0:`DR_DIR_N-1];
  reg [12:0] dir_pre [0:`DR_DIR_N-1];
  reg [12:0] dir_rot [0:`DR_DIR_N-1];
  reg [16:0] dir_len [0:`DR_DIR_N-1];
  reg [31:0] dir_ct [0:`DR_DIR_N-1];
  reg [31:0] dir_vt [0:`DR_DIR_N-1];
  reg [31:0] dir_ach [0:`DR_DIR_N-1];
  reg [4:0] head_r;
  reg [5:0] cnt_r;
  integer i;

  // Lengths in samples: duration counts 0.01 s steps
  // Full width product, cut on purpose below; 1050 x 6 still fits 13 bits
  wire [31:0] dur_prod_w = dur_r * `DR_SMP_PER_CS;
  wire [12:0] total_w = dur_prod_w[12:0];
  wire [23:0] pre_prod_w = total_w * pos_r;
  wire [23:0] pre_q_w = pre_prod_w / `DR_POS_DIV;
  wire [12:0] pre_len_w = pre_q_w[12:0];
  wire [12:0] post_len_w = total_w - pre_len_w;

  wire [`DR_SMP_W-1:0] word_w;
  wire [31:0] dig_cur_w;
  wire [31:0] hit_w;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_an
      assign word_w[g*`DR_AN_W +: `DR_AN_W] = an_pick(ach_r[g*4 +: 4]);
    end
    for (g = 0; g < `DR_DCH_N; g = g + 1) begin : g_dig
      assign dig_cur_w[g] = dig_src[dcfg_r[g][5:0]];
      assign hit_w[g] = ((dcfg_r[g][7:6] == `DR_TRIG_LH) && dig_cur_w[g] && !dig_prev_r[g]) ||
                        ((dcfg_r[g][7:6] == `DR_TRIG_HL) && !dig_cur_w[g] && dig_prev_r[g]);
    end
  endgenerate
  assign word_w[`DR_SMP_W-1:128] = dig_cur_w;

  wire hit_any_w = (|hit_w) && ctrl_r[`DR_CTRL_EN];
  wire [4:0] oldest_w = head_r - cnt_r[4:0];

  reg [`DR_AW-1:0] wa;
  reg [16:0] len_nx;
  reg [12:0] post_nx;
  reg cap_go;
  reg do_wr;
  reg close;
  always @* begin
    wa = base_r + {4'h0, hist_r};
    len_nx = len_r;
    post_nx = post_r;
    cap_go = 1'b0;
    do_wr = 1'b0;
    if (st_r == ST_IDLE) begin
      if (hit_any_w) begin
        wa = base_r + {4'h0, pre_cnt_r};
        len_nx = {4'h0, pre_cnt_r} + 17'h00001;
        post_nx = 13'h0001;
        cap_go = 1'b1;
        do_wr = 1'b1;
      end else begin
        do_wr = (pre_len_w != 13'h0000) && ctrl_r[`DR_CTRL_EN];
      end
    end else begin
      wa = base_r + len_r;
      len_nx = len_r + 17'h00001;
      // Single mode: further hits are ignored here
      post_nx = (ctrl_r[`DR_CTRL_EXT] && hit_any_w) ? 13'h0001 : post_r + 13'h0001;
      cap_go = 1'b1;
      do_wr = 1'b1;
    end
    // Cap stops an endless extended capture eating itself
    close = cap_go && ((post_nx >= post_len_w) || (len_nx == `DR_LEN_CAP));
  end

  wire drop_w = sample_valid && do_wr && (cnt_r != 6'h00) && (wa == dir_start[oldest_w]);

  // Capture engine
  always @(posedge mclk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      base_r <= {`DR_AW{1'b0}};
      hist_r <= 13'h0000;
      pre_cnt_r <= 13'h0000;
      post_r <= 13'h0000;
      len_r <= 17'h00000;
      rec_pre_r <= 13'h0000;
      rec_rot_r <= 13'h0000;
      dig_prev_r <= 32'h00000000;
      head_r <= 5'h00;
      cnt_r <= 6'h00;
      capture_active <= 1'b0;
    end else if (ce) begin
      capture_active <= (st_r == ST_POST);
      if (sample_valid) begin
        dig_prev_r <= dig_cur_w;
        if (do_wr)
          mem[wa] <= word_w;
        if (st_r == ST_IDLE && !cap_go && do_wr) begin
          // History ring of pre-trigger length after the newest record
          if (hist_r >= pre_len_w || pre_cnt_r > pre_len_w) begin
            hist_r <= 13'h0000;
            pre_cnt_r <= 13'h0000;
          end else begin
            hist_r <= (hist_r + 13'h0001 == pre_len_w) ? 13'h0000 : hist_r + 13'h0001;
            if (pre_cnt_r != pre_len_w)
              pre_cnt_r <= pre_cnt_r + 13'h0001;
          end
        end
        if (st_r == ST_IDLE && cap_go) begin
          rec_pre_r <= pre_cnt_r;
          rec_rot_r <= (pre_cnt_r == pre_len_w) ? hist_r : 13'h0000;
        end
        if (cap_go) begin
          len_r <= len_nx;
          post_r <= post_nx;
          st_r <= ST_POST;
        end
        if (close) begin
          dir_start[head_r] <= base_r;
          dir_pre[head_r] <= (st_r == ST_IDLE) ? pre_cnt_r : rec_pre_r;
          dir_rot[head_r] <= (st_r == ST_IDLE) ? ((pre_cnt_r == pre_len_w) ? hist_r : 13'h0000) :
                             rec_rot_r;
          dir_len[head_r] <= len_nx;
          dir_ct[head_r] <= (ct_r[31:16] == 16'h0000) ? 32'h00000000 : ct_r;
          dir_vt[head_r] <= vt_r;
          dir_ach[head_r] <= ach_r;
          head_r <= head_r + 5'h01;
          base_r <= base_r + len_nx;
          hist_r <= 13'h0000;
          pre_cnt_r <= 13'h0000;
          len_r <= 17'h00000;
          post_r <= 13'h0000;
          st_r <= ST_IDLE;
        end
        // Full directory: the new slot replaces the oldest
        if (close && !drop_w && cnt_r != `DR_DIR_N)
          cnt_r <= cnt_r + 6'h01;
        else if (!close && drop_w)
          cnt_r <= cnt_r - 6'h01;
      end
    end
  end

  // Readback of a stored record; history part is unrotated here
  wire [4:0] rslot_w = head_r - 5'h01 - rsel_r;
  wire rvalid_w = ({1'b0, rsel_r} < cnt_r);
  wire [12:0] rpre_w = dir_pre[rslot_w];
  wire [13:0] roff_w = {1'b0, dir_rot[rslot_w]} + rptr_r[13:0];
  reg [16:0] rofs;
  always @* begin
    rofs = rptr_r;
    if (rptr_r < {4'h0, rpre_w})
      rofs = (roff_w >= {1'b0, rpre_w}) ? {3'h0, roff_w - {1'b0, rpre_w}} : {3'h0, roff_w};
  end
  wire [`DR_AW-1:0] raddr_w = dir_start[rslot_w] + rofs;
  wire [3:0] rsrc_w = dir_ach[rslot_w][rword_r*4 +: 4];

  wire [7:0] badr_w = {wb_adr_i[7:2], 2'b00};
  wire wb_go_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [31:0] cur_dcfg_w = {22'h000000, dcfg_r[didx_r][7:6], 2'h0, dcfg_r[didx_r][5:0]};

  reg [31:0] rd;
  always @* begin
    case (badr_w)
      `DR_REG_CTRL: rd = {30'h00000000, ctrl_r};
      `DR_REG_DUR: rd = {21'h000000, dur_r};
      `DR_REG_POS: rd = {22'h000000, pos_r};
      `DR_REG_STAT: rd = {11'h000, head_r, 2'h0, cnt_r, 7'h00, capture_active};
      `DR_REG_ACH: rd = ach_r;
      `DR_REG_CT: rd = ct_r;
      `DR_REG_VT: rd = vt_r;
      `DR_REG_DIDX: rd = {27'h0000000, didx_r};
      `DR_REG_DCFG: rd = cur_dcfg_w;
      `DR_REG_RSEL: rd = {27'h0000000, rsel_r};
      `DR_REG_RINFO: rd = {rvalid_w, 1'b0, rpre_w, dir_len[rslot_w]};
      `DR_REG_RPTR: rd = {15'h0000, rptr_r};
      `DR_REG_RWORD: rd = {29'h00000000, rword_r};
      `DR_REG_RDATA: rd = (rword_r > 3'h4) ? 32'h00000000 : mem_q_r[rword_r*32 +: 32];
      `DR_REG_SCALE: rd = is_current(rsrc_w) ? dir_ct[rslot_w] : dir_vt[rslot_w];
      default: rd = 32'h00000000;
    endcase
  end

  reg [31:0] wv;
  always @* begin
    wv = wmerge(rd, wb_dat_i, wb_sel_i);
  end

  // Wishbone slave: ack one cycle after the request is seen
  always @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      mem_q_r <= {`DR_SMP_W{1'b0}};
      ctrl_r <= `DR_CTRL_DEF;
      dur_r <= `DR_DUR_DEF;
      pos_r <= `DR_POS_DEF;
      ach_r <= `DR_ACH_DEF;
      ct_r <= `DR_RATIO_DEF;
      vt_r <= `DR_RATIO_DEF;
      didx_r <= 5'h00;
      rsel_r <= 5'h00;
      rptr_r <= 17'h00000;
      rword_r <= 3'h0;
      for (i = 0; i < `DR_DCH_N; i = i + 1)
        dcfg_r[i] <= {(i == `DR_TRIP_CH) ? `DR_TRIG_LH : `DR_TRIG_NONE, i[5:0]};
    end else if (ce) begin
      // Stale for one cycle after a pointer write; the bus gap covers it
      mem_q_r <= mem[raddr_w];
      wb_ack_o <= wb_go_w;
      if (wb_go_w && !wb_we_i)
        wb_dat_o <= rd;
      if (wb_go_w && wb_we_i) begin
        case (badr_w)
          `DR_REG_CTRL: ctrl_r <= wv[1:0];
          `DR_REG_DUR: dur_r <= (wv[10:0] < `DR_DUR_MIN) ? `DR_DUR_MIN :
                                (wv[10:0] > `DR_DUR_MAX) ? `DR_DUR_MAX : wv[10:0];
          `DR_REG_POS: pos_r <= (wv[9:0] > `DR_POS_MAX) ? `DR_POS_MAX : wv[9:0];
          `DR_REG_ACH: ach_r <= wv;
          `DR_REG_CT: ct_r <= wv;
          `DR_REG_VT: vt_r <= wv;
          `DR_REG_DIDX: didx_r <= wv[4:0];
          `DR_REG_DCFG: dcfg_r[didx_r] <= {wv[9:8], wv[5:0]};
          `DR_REG_RSEL: rsel_r <= wv[4:0];
          `DR_REG_RPTR: rptr_r <= wv[16:0];
          `DR_REG_RWORD: rword_r <= wv[2:0];
          default: ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/dr_recorder_assertions.sv
// Port checker of the disturbance recorder, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module dr_chk (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire sample_valid,
  input wire capture_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  reset_clear_a: assert property (disable iff (1'b0)
    reset |=> !wb_ack_o && !capture_active && wb_dat_o == 32'h0) else $error("reset state wrong");
  // Capture flag lags the sample by one or two edges
  capture_start_a: assert property ($rose(capture_active) |->
    $past(sample_valid) || $past(sample_valid, 2)) else $error("start off sample");
  capture_end_a: assert property ($fell(capture_active) |->
    $past(sample_valid) || $past(sample_valid, 2)) else $error("end off sample");
  ce_freeze_a: assert property (!ce |=> $stable(wb_ack_o) && $stable(capture_active))
    else $error("state moved with ce low");
  dat_hold_a: assert property (
    !$past(wb_cyc_i && wb_stb_i && !wb_we_i) |-> $stable(wb_dat_o)) else $error("read data moved");
  cover property (capture_active [*3]);
  cover property ($fell(capture_active));
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind dr_recorder dr_chk i_chk (.mclk(mclk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_valid(sample_valid), .capture_active(capture_active));
`default_nettype wire

// >>> testbench/dr_front_end.sv
// Front end model: sample strobe and patterned analog channels
`timescale 1ns/100ps
`default_nettype none
module dr_front_end #(
  parameter int GAP = 5
) (
  input wire logic mclk,
  input wire logic reset,
  output logic sample_valid,
  output logic [143:0] an_bus
);
  logic [7:0] cnt_r;
  logic [11:0] seq_r;
  // Rate far above mains timing to keep runs short
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= 8'h00;
      seq_r <= 12'h000;
      sample_valid <= 1'h0;
    end else begin
      cnt_r <= (cnt_r == GAP - 1) ? 8'h00 : cnt_r + 8'h01;
      sample_valid <= (cnt_r == GAP - 1);
      if (sample_valid) seq_r <= seq_r + 12'h001;
    end
  end
  // Channel number in the top nibble, sample index below
  for (genvar k = 0; k < 9; k++) begin : g_ch
    assign an_bus[16 * k +: 16] = {4'(k), seq_r};
  end
endmodule
`default_nettype wire

// >>> testbench/tb_disturbance_recorder.sv
// Self-checking bench of the disturbance recorder
`timescale 1ns/100ps
`default_nettype none
`include "dr_consts.vh"
module tb_disturbance_recorder;
  logic mclk = 1'h0, reset = 1'h1, ce = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, tdig, rs = 32'h0FD3;
  logic [63:0] dig = 64'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, sample_valid, capture_active;
  wire [143:0] an;
  int n_errors = 0, n_checks = 0, ns = 0, n, tseq;
  dr_recorder i_dut (.mclk(mclk), .reset(reset), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_valid(sample_valid), .phase_a_voltage(an[15:0]),
    .phase_b_voltage(an[31:16]), .phase_c_voltage(an[47:32]), .sync_check_voltage(an[63:48]),
    .phase_a_current(an[79:64]), .phase_b_current(an[95:80]), .phase_c_current(an[111:96]),
    .neutral_current(an[127:112]), .sensitive_earth_current(an[143:128]), .dig_src(dig),
    .capture_active(capture_active));
  dr_front_end #(.GAP(5)) i_fe (.mclk(mclk), .reset(reset), .sample_valid(sample_valid),
    .an_bus(an));
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (sample_valid) ns <= ns + 1;
  end
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] rinfo(input int p, input int l);
    return {2'h2, p[12:0], l[16:0]};
  endfunction
  function automatic logic [31:0] aword(input int s);
    return {4'h1, s[11:0], 4'h0, s[11:0]};
  endfunction
  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, s, e);
    end
  endtask
  // Request held until ack is seen at an edge, then released there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (wb_ack_o === 1'h1) break;
    end
    q = wb_dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (k == 50) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  // Idle samples with noise on channels that must not trigger
  task automatic ws(input int m);
    logic [31:0] r;
    repeat (m * 5) begin
      @(posedge mclk);
      r = xs();
      dig[63:32] <= xs();
      dig[31:8] <= r[23:0];
    end
  endtask
  // Trigger on channel 2 with level p; optional retrigger at post sample rt
  task automatic cap(input logic p, input int rt, output int n);
    int k;
    logic up;
    logic drv;
    logic lvl;
    n = 0;
    up = 1'h0;
    dig[2] <= ~p;
    ws(40);
    dig[2] <= p;
    for (k = 0; k < 4000; k++) begin
      #1;
      if (capture_active === 1'h1) up = 1'h1;
      if (up && capture_active !== 1'h1) break;
      drv = 1'h0;
      lvl = p;
      if (sample_valid) begin
        n++;
        if (n == 1) begin
          tseq = ns;
          tdig = dig[31:0];
        end
      end else if (rt > 0 && n == 1) begin
        drv = 1'h1;
        lvl = ~p;
      end else if (rt > 0 && n == rt - 1) begin
        drv = 1'h1;
        lvl = p;
      end
      // Pin changes only by NBA right at the rising edge
      @(posedge mclk);
      if (drv) dig[2] <= lvl;
    end
    if (k == 4000) begin
      n_errors++;
      conclude();
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'h0;
    rc(`DR_REG_CTRL, 32'h1);
    rc(`DR_REG_DUR, 32'h96);
    rc(`DR_REG_POS, 32'h14D);
    rc(`DR_REG_ACH, 32'h87654210);
    rc(`DR_REG_CT, 32'h10000);
    rc(8'h1C, 32'h0);
    bus(1'h1, `DR_REG_DIDX, 32'h3);
    rc(`DR_REG_DCFG, 32'h3);
    bus(1'h1, `DR_REG_DIDX, 32'h2);
    rc(`DR_REG_DCFG, 32'h102);
    bus(1'h1, `DR_REG_DUR, 32'h5);
    rc(`DR_REG_DUR, 32'hA);
    bus(1'h1, `DR_REG_DUR, 32'h7FF);
    rc(`DR_REG_DUR, 32'h41A);
    bus(1'h1, `DR_REG_POS, 32'h3FF);
    rc(`DR_REG_POS, 32'h3E8);
    // 0.1 s at mid position: 30 pre and 30 post samples
    bus(1'h1, `DR_REG_DUR, 32'hA);
    bus(1'h1, `DR_REG_POS, 32'h1F4);
    cap(1'h1, 0, n);
    chk(n, 30);
    rc(`DR_REG_RINFO, rinfo(30, 60));
    bus(1'h1, `DR_REG_RSEL, 32'h0);
    bus(1'h1, `DR_REG_RPTR, 32'h1E);
    bus(1'h1, `DR_REG_RWORD, 32'h4);
    rc(`DR_REG_RDATA, tdig);
    bus(1'h1, `DR_REG_RPTR, 32'h0);
    bus(1'h1, `DR_REG_RWORD, 32'h0);
    rc(`DR_REG_RDATA, aword(tseq - 30));
    cap(1'h1, 10, n);
    chk(n, 30);
    bus(1'h1, `DR_REG_CTRL, 32'h3);
    bus(1'h1, `DR_REG_CT, 32'h8000);
    cap(1'h1, 10, n);
    chk(n, 39);
    rc(`DR_REG_RINFO, rinfo(30, 69));
    bus(1'h1, `DR_REG_RWORD, 32'h3);
    rc(`DR_REG_SCALE, 32'h0);
    bus(1'h1, `DR_REG_RWORD, 32'h0);
    rc(`DR_REG_SCALE, 32'h10000);
    bus(1'h1, `DR_REG_CTRL, 32'h1);
    bus(1'h1, `DR_REG_DCFG, 32'h202);
    cap(1'h0, 0, n);
    chk(n, 30);
    bus(1'h1, `DR_REG_DCFG, 32'h2);
    dig[2] <= 1'h1;
    ws(3);
    dig[2] <= 1'h0;
    ws(3);
    bus(1'h0, `DR_REG_STAT, 32'h0);
    chk(q[13:0], 32'h400);
    // Directory holds 32; older records give way
    bus(1'h1, `DR_REG_DCFG, 32'h102);
    repeat (30) cap(1'h1, 0, n);
    bus(1'h0, `DR_REG_STAT, 32'h0);
    chk(q[13:8], 32'h20);
    rc(`DR_REG_RINFO, rinfo(30, 60));
    // Rising trip edge while frozen must leave no record; head stays at 34 mod 32
    ce <= 1'h0;
    dig[2] <= 1'h0;
    ws(3);
    dig[2] <= 1'h1;
    ws(3);
    ce <= 1'h1;
    rc(`DR_REG_STAT, 32'h00022000);
    conclude();
  end
endmodule
`default_nettype wire
